// ==== dv/vsf_analog_model.sv ====
// Behavioural model of the ringing and current comparators.
`timescale 1ns/1ps
`default_nettype none
module vsf_analog_model (
  input  wire logic       sys_clk,
  input  wire logic       gate_drive,
  input  wire logic [2:0] zc_num,
  output logic            zero_cross_input,
  output logic            cs_trip
);
  int unsigned t;
  int unsigned on_t;
  always @(posedge sys_clk) begin
    t <= gate_drive ? 0 : t + 1;
    on_t <= gate_drive ? on_t + 1 : 0;
  end
  // Ringing dips every 20 off cycles, zc_num times, then stays high.
  assign zero_cross_input = !(t >= 20 && t % 20 < 4 && t / 20 <= zc_num);
  // Current sense reaches feedback a fixed time into the on-time.
  assign cs_trip = gate_drive && on_t >= 8;
endmodule
`default_nettype wire

// ==== dv/vsf_checker.sv ====
// Concurrent checks on the ports of the frequency reducer.
`timescale 1ns/1ps
`default_nettype none
module vsf_checker #(
  parameter int unsigned SS_STEP  = 50,
  parameter int unsigned OFF_MAX  = 300,
  parameter int unsigned RING_SHT = 10
) (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       cs_trip,
  input wire logic       gate_drive,
  input wire logic       charger_enable,
  input wire logic [1:0] cs_limit_step,
  input wire logic [2:0] valley_count,
  input wire logic [2:0] zc_count
);
  int unsigned off_cnt;
  int unsigned ss_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge sys_clk) begin
    off_cnt <= (sys_rst || gate_drive || charger_enable) ? 0 : off_cnt + 1;
    ss_cnt  <= (sys_rst || $changed(cs_limit_step)) ? 0 : ss_cnt + 1;
  end
  property p_rst; $fell(sys_rst) |-> valley_count == 3'h1 &&
    zc_count == 3'h0 && !gate_drive && charger_enable; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_vrng; valley_count inside {[3'h1:3'h7]}; endproperty
  a_vrng: assert property (p_vrng) else $error("valley range");
  property p_vstp; $changed(valley_count) |-> valley_count == 3'h1 ||
    valley_count == $past(valley_count) + 3'h1 ||
    valley_count == $past(valley_count) - 3'h1; endproperty
  a_vstp: assert property (p_vstp) else $error("valley step");
  property p_zstp; $changed(zc_count) |-> zc_count == 3'h0 ||
    zc_count == $past(zc_count) + 3'h1; endproperty
  a_zstp: assert property (p_zstp) else $error("zc step");
  property p_zclr; $rose(gate_drive) |-> ##2 zc_count == 3'h0; endproperty
  a_zclr: assert property (p_zclr) else $error("zc not cleared");
  property p_on; $rose(gate_drive) |-> off_cnt >= RING_SHT - 1 &&
    (zc_count >= valley_count || off_cnt >= OFF_MAX - 4);
  endproperty
  a_on: assert property (p_on) else $error("early turn-on");
  property p_offmax; off_cnt <= OFF_MAX + 2; endproperty
  a_offmax: assert property (p_offmax) else $error("off too long");
  property p_off; cs_trip && gate_drive |-> ##[1:4] !gate_drive; endproperty
  a_off: assert property (p_off) else $error("no turn-off");
  property p_chg; !charger_enable |=> !charger_enable; endproperty
  a_chg: assert property (p_chg) else $error("charger back on");
  property p_ss; $changed(cs_limit_step) |->
    cs_limit_step == $past(cs_limit_step) + 2'h1; endproperty
  a_ss: assert property (p_ss) else $error("soft-start step");
  property p_sslen; $changed(cs_limit_step) && $past(cs_limit_step) != 2'h0
    |-> ss_cnt == SS_STEP - 1; endproperty
  a_sslen: assert property (p_sslen) else $error("step length");
  c_gate: cover property ($rose(gate_drive));
  c_vmax: cover property (valley_count == 3'h7);
  c_ssend: cover property (cs_limit_step == 2'h3);
endmodule
bind vsf_top vsf_checker #(.SS_STEP(SS_STEP), .OFF_MAX(OFF_MAX),
  .RING_SHT(RING_SHT)) i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .cs_trip(cs_trip), .gate_drive(gate_drive),
  .charger_enable(charger_enable), .cs_limit_step(cs_limit_step),
  .valley_count(valley_count), .zc_count(zc_count));
`default_nettype wire

// ==== dv/vsf_top_test.sv ====
// Self-checking testbench for the frequency reducer.
`timescale 1ns/1ps
`default_nettype none
module vsf_top_test;
  localparam int unsigned PRD  = 200;
  localparam int unsigned OFFM = 300;
  logic       sys_clk, sys_rst, supply_on, line_high, ring_short;
  logic       lo_l, hi_l, lo_h, hi_h, reload, zc, cs_trip, gate, chg;
  logic [1:0] step;
  logic [2:0] valley, zcc, zc_num;
  int         n_fail, checks;
  vsf_top #(.PERIOD(PRD), .SS_STEP(50), .OFF_MAX(OFFM), .RING_LNG(80),
    .RING_SHT(10)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .supply_on(supply_on), .line_high(line_high),
    .fb_above_low_lo_line(lo_l), .fb_above_high_lo_line(hi_l),
    .fb_above_low_hi_line(lo_h), .fb_above_high_hi_line(hi_h),
    .fb_above_reload(reload), .zero_cross_input(zc),
    .zc_above_ring_thr(ring_short), .cs_trip(cs_trip), .gate_drive(gate),
    .charger_enable(chg), .cs_limit_step(step), .valley_count(valley),
    .zc_count(zcc));
  vsf_analog_model i_ana (.sys_clk(sys_clk), .gate_drive(gate),
    .zc_num(zc_num), .zero_cross_input(zc), .cs_trip(cs_trip));
  task automatic wc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %0h vs %0h", $time, got, exp);
    end
  endtask
  // The unselected comparator pair shows the opposite levels.
  task automatic set_fb(input int lvl);
    {lo_l, hi_l} = line_high ? {lvl < 1, lvl < 2} : {lvl > 0, lvl > 1};
    {lo_h, hi_h} = line_high ? {lvl > 0, lvl > 1} : {lvl < 1, lvl < 2};
    reload = lvl > 2;
  endtask
  task automatic t_soft;
    supply_on = 1'b1;
    wc(8);
    chk({2'h0, chg}, 3'h0);
    wc(17);
    for (int i = 0; i < 5; i++) begin
      chk({1'b0, step}, (i > 3) ? 3'h3 : 3'(i));
      wc(50);
    end
  endtask
  task automatic t_count(input int lvl, input logic ln);
    logic [2:0] e;
    line_high = ln;
    set_fb(lvl);
    wc(PRD);
    case (lvl)
      0: e = (valley == 3'h7) ? 3'h7 : valley + 3'h1;
      1: e = valley;
      2: e = (valley == 3'h1) ? 3'h1 : valley - 3'h1;
      default: e = 3'h1;
    endcase
    wc(PRD);
    chk(valley, e);
  endtask
  task automatic t_sw(input logic [2:0] zn, input logic rs, input int lo, hi);
    int n;
    zc_num = zn;
    ring_short = rs;
    for (n = 0; !gate && n < 2000; n++) wc(1);
    for (n = 0; gate && n < 2000; n++) wc(1);
    for (n = 0; !gate && n < 2000; n++) wc(1);
    chk({2'h0, n >= lo && n <= hi}, 3'h1);
  endtask
  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    n_fail++;
    results;
  end
  initial begin
    int lv[9] = '{0, 0, 0, 0, 1, 2, 1, 3, 0};
    sys_rst = 1'b1;
    supply_on = 1'b0;
    line_high = 1'b0;
    ring_short = 1'b1;
    zc_num = 3'h7;
    n_fail = 0;
    checks = 0;
    set_fb(0);
    wc(2);
    sys_rst = 1'b0;
    wc(1);
    chk(valley, 3'h1);
    chk({gate, chg, zcc == 3'h0}, 3'h3);
    wc(2);
    t_soft();
    for (int i = 0; i < 9; i++) t_count(lv[i], i[0]);
    set_fb(1);
    t_sw(3'h3, 1'b1, 40, 50);
    t_sw(3'h3, 1'b0, 77, 88);
    t_sw(3'h1, 1'b1, OFFM - 5, OFFM + 5);
    set_fb(3);
    wc(6);
    set_fb(1);
    wc(PRD);
    chk(valley, 3'h1);
    results();
  end
endmodule
`default_nettype wire

// ==== include/vsf_period_if.sv ====
// Interface carrying period ticks and the valley number between modules.
`timescale 1ns/1ps
`default_nettype none
interface vsf_period_if;
  logic       period_end;
  logic       run;
  logic [2:0] valley;

  modport timer (output period_end, input run, input valley);
  modport ctrl  (input period_end, output run, output valley);
endinterface
`default_nettype wire

// ==== include/vsf_pkg.sv ====
// Package with constants and types for the valley-select frequency reducer.
package vsf_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 200_000_000;
  localparam int unsigned PERIOD_MS        = 48;
  localparam int unsigned SOFTSTART_MS     = 12;
  localparam int unsigned SOFTSTART_STEPS  = 4;
  localparam int unsigned PERIOD_CYC       = CLK_HZ / 1000 * PERIOD_MS;
  localparam int unsigned SOFTSTART_CYC    = CLK_HZ / 1000 * SOFTSTART_MS;
  localparam int unsigned SS_STEP_CYC      = SOFTSTART_CYC / SOFTSTART_STEPS;
  localparam int unsigned RING_LONG_NS     = 2500;
  localparam int unsigned RING_SHORT_NS    = 500;
  localparam int unsigned OFF_MAX_US       = 50;
  localparam int unsigned RING_LONG_CYC    = RING_LONG_NS / 5;
  localparam int unsigned RING_SHORT_CYC   = RING_SHORT_NS / 5;
  localparam int unsigned OFF_MAX_CYC      = CLK_HZ / 1_000_000 * OFF_MAX_US;

  // ----------------------------------------------------------------------
  // Counter limits and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] VALLEY_MIN   = 3'h1;
  localparam logic [2:0] VALLEY_MAX   = 3'h7;
  localparam logic [2:0] VALLEY_RST   = 3'h1;
  localparam logic [2:0] ZC_MAX       = 3'h7;
  localparam logic [2:0] ZC_RST       = 3'h0;
  localparam logic [1:0] SS_STEP_RST  = 2'h0;
  localparam logic [1:0] SS_STEP_LAST = 2'h3;

  typedef enum logic [1:0] {
    VSF_WAIT_SUPPLY = 2'b00,
    VSF_SOFTSTART   = 2'b01,
    VSF_RUN         = 2'b10
  } vsf_phase_t;

endpackage

// ==== logic/vsf_period_timer.sv ====
// Free-running period divider producing one-cycle period-end pulses.
`timescale 1ns/1ps
`default_nettype none
module vsf_period_timer #(
  parameter int unsigned PERIOD = vsf_pkg::PERIOD_CYC
) (
  input  wire logic   sys_clk,
  input  wire logic   sys_rst,
  vsf_period_if.timer prd
);
  import vsf_pkg::*;

  logic [31:0] cnt_r;
  logic        tick_r;
  wire         wrap = (cnt_r == 32'(PERIOD - 1));

  // Counter restarts when running begins so the first period is full.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !prd.run) begin
      cnt_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= wrap ? 32'h0 : cnt_r + 32'h1;
      tick_r <= wrap;
    end
  end

  assign prd.period_end = tick_r;
endmodule
`default_nettype wire

// ==== logic/vsf_top.sv ====
// Valley-select frequency reduction, soft-start and switch-on control.
//
// Contract
// - Sample feedback levels each 48 ms period.
// - All-period below low threshold: count up.
// - Low crossed, high never: hold counter.
// - High crossed, reload never: count down.
// - Reload threshold crossed: load counter with one.
// - Valley counter stays within one to seven.
// - Valley counter starts at one.
// - Soft-start 12 ms, four equal limit steps.
// - Turn-on digital, turn-off from analog comparator.
// - Turn-on uses zero cross and valley count.
// - Valley count is switch-on zero-cross ordinal.
// - Threshold set chosen by line level.
// - Supply threshold stops charger, starts soft-start.
// - Zero-cross counter 0..7, cleared on gate high.
// - After ringing time, turn on at count match.
// - Maximum off time forces turn-on.
`timescale 1ns/1ps
`default_nettype none
module vsf_top #(
  parameter int unsigned PERIOD   = vsf_pkg::PERIOD_CYC,
  parameter int unsigned SS_STEP  = vsf_pkg::SS_STEP_CYC,
  parameter int unsigned OFF_MAX  = vsf_pkg::OFF_MAX_CYC,
  parameter int unsigned RING_LNG = vsf_pkg::RING_LONG_CYC,
  parameter int unsigned RING_SHT = vsf_pkg::RING_SHORT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       supply_on,
  input  wire logic       line_high,
  input  wire logic       fb_above_low_lo_line,
  input  wire logic       fb_above_high_lo_line,
  input  wire logic       fb_above_low_hi_line,
  input  wire logic       fb_above_high_hi_line,
  input  wire logic       fb_above_reload,
  input  wire logic       zero_cross_input,
  input  wire logic       zc_above_ring_thr,
  input  wire logic       cs_trip,
  output logic            gate_drive,
  output logic            charger_enable,
  output logic [1:0]      cs_limit_step,
  output logic [2:0]      valley_count,
  output logic [2:0]      zc_count
);
  import vsf_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int NIN = 11;
  logic [NIN-1:0] s1_r;
  logic [NIN-1:0] s2_r;
  wire  [NIN-1:0] raw = {supply_on, line_high, fb_above_low_lo_line,
                         fb_above_high_lo_line, fb_above_low_hi_line,
                         fb_above_high_hi_line, fb_above_reload,
                         zero_cross_input, zc_above_ring_thr, cs_trip,
                         1'b0};
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end
  wire sup_s  = s2_r[10];
  wire line_s = s2_r[9];
  wire zc_s   = s2_r[3];
  wire ring_s = s2_r[2];
  wire cs_s   = s2_r[1];
  // Line level picks which comparator pair is counted.
  wire low_s  = line_s ? s2_r[6] : s2_r[8];
  wire high_s = line_s ? s2_r[5] : s2_r[7];
  wire rld_s  = s2_r[4];

  // ----------------------------------------------------------------------
  // Start-up phase and soft-start
  // ----------------------------------------------------------------------
  vsf_phase_t  phase_r;
  logic [31:0] ss_cnt_r;
  logic [1:0]  ss_step_r;
  wire ss_wrap = (ss_cnt_r == 32'(SS_STEP - 1));
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_r   <= VSF_WAIT_SUPPLY;
      ss_cnt_r  <= 32'h0;
      ss_step_r <= SS_STEP_RST;
    end else begin
      unique case (phase_r)
        VSF_WAIT_SUPPLY: begin
          if (sup_s) begin
            phase_r <= VSF_SOFTSTART;
          end
        end
        VSF_SOFTSTART: begin
          ss_cnt_r <= ss_wrap ? 32'h0 : ss_cnt_r + 32'h1;
          if (ss_wrap) begin
            if (ss_step_r == SS_STEP_LAST) begin
              phase_r <= VSF_RUN;
            end else begin
              ss_step_r <= ss_step_r + 2'h1;
            end
          end
        end
        VSF_RUN: begin
        end
        default: begin
          phase_r <= VSF_WAIT_SUPPLY;
        end
      endcase
    end
  end
  wire running = (phase_r != VSF_WAIT_SUPPLY);

  // ----------------------------------------------------------------------
  // Period timer and valley-select counter
  // ----------------------------------------------------------------------
  vsf_period_if prd ();
  assign prd.run    = running;
  vsf_period_timer #(.PERIOD(PERIOD)) u_timer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .prd     (prd)
  );

  logic       saw_low_r;
  logic       saw_high_r;
  logic       saw_rld_r;
  logic [2:0] valley_r;
  logic [2:0] valley_nxt;
  wire at_max = (valley_r == VALLEY_MAX);
  wire at_min = (valley_r == VALLEY_MIN);
  // Reload beats high beats low; clamps hold range 1..7.
  assign valley_nxt = saw_rld_r  ? VALLEY_RST :
                      saw_high_r ? (at_min ? valley_r
                                           : valley_r - 3'h1) :
                      saw_low_r  ? valley_r :
                      (at_max ? valley_r : valley_r + 3'h1);
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !running) begin
      saw_low_r  <= 1'b0;
      saw_high_r <= 1'b0;
      saw_rld_r  <= 1'b0;
      valley_r   <= VALLEY_RST;
    end else if (prd.period_end) begin
      // A crossing in the closing cycle starts the next period's flags.
      saw_low_r  <= low_s;
      saw_high_r <= high_s;
      saw_rld_r  <= rld_s;
      valley_r   <= valley_nxt;
    end else begin
      saw_low_r  <= saw_low_r | low_s;
      saw_high_r <= saw_high_r | high_s;
      saw_rld_r  <= saw_rld_r | rld_s;
    end
  end
  assign prd.valley = valley_r;

  // ----------------------------------------------------------------------
  // Switch-on and switch-off
  // ----------------------------------------------------------------------
  logic        gate_r;
  logic        zc_d_r;
  logic [2:0]  zc_r;
  logic [31:0] off_cnt_r;
  logic [31:0] ring_lim_r;
  wire zc_fall  = zc_d_r && !zc_s;
  wire ring_ok  = (off_cnt_r >= ring_lim_r);
  wire match    = (zc_r >= prd.valley) && (zc_r != ZC_RST);
  wire force_on = (off_cnt_r >= 32'(OFF_MAX - 1));
  wire turn_on  = running && !gate_r && ((ring_ok && match) || force_on);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gate_r     <= 1'b0;
      zc_d_r     <= 1'b0;
      zc_r       <= ZC_RST;
      off_cnt_r  <= 32'h0;
      ring_lim_r <= 32'(RING_LNG);
    end else begin
      zc_d_r <= zc_s;
      if (gate_r) begin
        gate_r     <= !cs_s;
        off_cnt_r  <= 32'h0;
        zc_r       <= ZC_RST;
        ring_lim_r <= 32'(RING_LNG);
      end else if (turn_on) begin
        gate_r <= 1'b1;
      end else begin
        off_cnt_r <= off_cnt_r + 32'h1;
        if (off_cnt_r == 32'h0) begin
          ring_lim_r <= ring_s ? 32'(RING_SHT) : 32'(RING_LNG);
        end
        if (zc_fall && zc_r != ZC_MAX) begin
          zc_r <= zc_r + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      charger_enable <= 1'b1;
      cs_limit_step  <= SS_STEP_RST;
      valley_count   <= VALLEY_RST;
      zc_count       <= ZC_RST;
    end else begin
      charger_enable <= !running;
      cs_limit_step  <= ss_step_r;
      valley_count   <= valley_r;
      zc_count       <= zc_r;
    end
  end
  assign gate_drive = gate_r;
endmodule
`default_nettype wire
